// ### verilog/cso_pkg.sv
/*
 package for the store and stack execution unit: opcode kinds,
 cycle counts, reset values. assumes a single core clock domain.
*/
`default_nettype none
package cso_pkg;
    localparam int unsigned CSO_AW          = 16;
    localparam int unsigned CSO_DW          = 8;
    localparam int unsigned CSO_RW          = 5;
    localparam logic [3:0]  CSO_CYC_STORE   = 4'h2;
    localparam logic [3:0]  CSO_CYC_FL_RD   = 4'h3;
    localparam logic [3:0]  CSO_CYC_STACK   = 4'h2;
    localparam logic [3:0]  CSO_CYC_FL_WR   = 4'h2;
    localparam logic [15:0] CSO_SP_RESET    = 16'h05FF;
    localparam logic [4:0]  CSO_REG_R0      = 5'h00;
    localparam logic [4:0]  CSO_REG_R1      = 5'h01;

    typedef enum logic [3:0] {
        CSO_OP_NONE      = 4'h0,
        CSO_OP_DIRECT    = 4'h1,
        CSO_OP_IND       = 4'h2,
        CSO_OP_IND_INC   = 4'h3,
        CSO_OP_IND_DEC   = 4'h4,
        CSO_OP_OFFSET    = 4'h5,
        CSO_OP_FL_RD     = 4'h6,
        CSO_OP_FL_RD_INC = 4'h7,
        CSO_OP_FL_WR     = 4'h8,
        CSO_OP_PUSH      = 4'h9,
        CSO_OP_POP       = 4'hA,
        CSO_OP_BREAK     = 4'hB
    } cso_op_t;

    typedef enum logic [2:0] {
        CSO_FSM_IDLE = 3'b001,
        CSO_FSM_RUN  = 3'b010,
        CSO_FSM_DONE = 3'b100
    } cso_state_t;
endpackage
`default_nettype wire

// ### verilog/cso_cycle_count.sv
/*
 down counter that holds an instruction for its cycle count.
 assumes load is only given while idle.
*/
`timescale 1ns/1ns
`default_nettype none
module cso_cycle_count
    import cso_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic       load,
    input  wire logic [3:0] cycles,
    output logic            last
);
    logic [3:0] count;
    wire        busy = (count != 4'h0);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            count <= 4'h0;
        end else if (load) begin
            count <= cycles - 4'h1;
        end else if (busy) begin
            count <= count - 4'h1;
        end
    end

    assign last = (count == 4'h1) || (load && cycles == 4'h1);
endmodule
`default_nettype wire

// ### verilog/cso_exec.sv
/*
 execution unit for data stores, program memory access, push, pop
 and the debug break. assumes decode holds op/operands stable on
 start, that both memories take a write in one cycle, and that data
 memory answers a read while mem_re stands, flash on the next cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module cso_exec
    import cso_pkg::*;
#(
    parameter int unsigned AW = CSO_AW
) (
    input  wire logic          clk_sys,
    input  wire logic          rstn,
    input  wire logic          start,
    input  wire cso_op_t       op,
    input  wire logic [4:0]    reg_sel,
    input  wire logic [15:0]   ptr,
    input  wire logic [5:0]    disp,
    input  wire logic [15:0]   abs_addr,
    input  wire logic [7:0]    src_data,
    input  wire logic [15:0]   r1r0,
    input  wire logic [7:0]    mem_rdata,
    input  wire logic [7:0]    prog_rdata,
    output logic               busy,
    output logic               done,
    output logic               mem_we,
    output logic               mem_re,
    output logic [AW-1:0]      mem_addr,
    output logic [7:0]         mem_wdata,
    output logic               prog_re,
    output logic               prog_we,
    output logic [15:0]        prog_addr,
    output logic [15:0]        prog_wdata,
    output logic               ptr_we,
    output logic [15:0]        ptr_new,
    output logic               reg_we,
    output logic [4:0]         reg_waddr,
    output logic [7:0]         reg_wdata,
    output logic               debug_break,
    output logic [15:0]        sp
);
    cso_state_t state;
    cso_state_t next_state;
    cso_op_t    cur_op;
    logic [4:0] cur_reg;
    logic       last;

    function automatic logic [15:0] step16(input logic [15:0] v, input logic up);
        step16 = up ? v + 16'h0001 : v - 16'h0001;
    endfunction

    wire is_store = (op == CSO_OP_DIRECT) || (op == CSO_OP_IND) ||
                    (op == CSO_OP_IND_INC) || (op == CSO_OP_IND_DEC) ||
                    (op == CSO_OP_OFFSET);
    wire is_fl_rd = (op == CSO_OP_FL_RD) || (op == CSO_OP_FL_RD_INC);
    wire is_stack = (op == CSO_OP_PUSH) || (op == CSO_OP_POP);
    wire go       = start && (state == CSO_FSM_IDLE);
    wire [3:0] cyc_sel = is_fl_rd ? CSO_CYC_FL_RD :
                         is_stack ? CSO_CYC_STACK :
                         (op == CSO_OP_FL_WR) ? CSO_CYC_FL_WR : CSO_CYC_STORE;
    wire [15:0] disp_addr = ptr + {10'h000, disp};
    wire [15:0] dec_ptr   = step16(ptr, 1'b0);
    wire [15:0] inc_ptr   = step16(ptr, 1'b1);
    wire [15:0] sp_inc    = step16(sp, 1'b1);
    wire [15:0] store_addr = (op == CSO_OP_DIRECT) ? abs_addr :
                            (op == CSO_OP_OFFSET) ? disp_addr :
                            (op == CSO_OP_IND_DEC) ? dec_ptr : ptr;
    wire        go_ok     = go && (op != CSO_OP_NONE) && (op != CSO_OP_BREAK);

    cso_cycle_count u_count (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .load    (go_ok),
        .cycles  (cyc_sel),
        .last    (last)
    );

    always_comb begin
        case (state)
            CSO_FSM_IDLE: next_state = go_ok ? (last ? CSO_FSM_DONE : CSO_FSM_RUN) : CSO_FSM_IDLE;
            CSO_FSM_RUN:  next_state = last ? CSO_FSM_DONE : CSO_FSM_RUN;
            CSO_FSM_DONE: next_state = CSO_FSM_IDLE;
            default:      next_state = CSO_FSM_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state   <= CSO_FSM_IDLE;
            cur_op  <= CSO_OP_NONE;
            cur_reg <= 5'h00;
        end else begin
            state <= next_state;
            if (go_ok) begin
                cur_op  <= op;
                cur_reg <= reg_sel;
            end
        end
    end

    // first-cycle memory and pointer actions
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mem_we      <= 1'b0;
            mem_re      <= 1'b0;
            mem_addr    <= '0;
            mem_wdata   <= 8'h00;
            prog_re     <= 1'b0;
            prog_we     <= 1'b0;
            prog_addr   <= 16'h0000;
            prog_wdata  <= 16'h0000;
            ptr_we      <= 1'b0;
            ptr_new     <= 16'h0000;
            debug_break <= 1'b0;
            sp          <= CSO_SP_RESET;
        end else begin
            mem_we      <= go_ok && (is_store || op == CSO_OP_PUSH);
            mem_re      <= go_ok && (op == CSO_OP_POP);
            prog_re     <= go_ok && is_fl_rd;
            prog_we     <= go_ok && (op == CSO_OP_FL_WR);
            debug_break <= go && (op == CSO_OP_BREAK);
            ptr_we      <= go_ok && (op == CSO_OP_IND_INC || op == CSO_OP_IND_DEC ||
                                     op == CSO_OP_FL_RD_INC);
            ptr_new     <= (op == CSO_OP_IND_DEC) ? dec_ptr : inc_ptr;
            if (go_ok) begin
                mem_addr   <= AW'((op == CSO_OP_PUSH) ? sp :
                                  (op == CSO_OP_POP) ? sp_inc : store_addr);
                mem_wdata  <= src_data;
                prog_addr  <= ptr;
                prog_wdata <= r1r0;
                if (op == CSO_OP_PUSH) begin
                    sp <= step16(sp, 1'b0);
                end else if (op == CSO_OP_POP) begin
                    sp <= sp_inc;
                end
            end
        end
    end

    // completion and register writeback
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            busy      <= 1'b0;
            done      <= 1'b0;
            reg_we    <= 1'b0;
            reg_waddr <= 5'h00;
            reg_wdata <= 8'h00;
        end else begin
            busy   <= (next_state != CSO_FSM_IDLE);
            done   <= ((state != CSO_FSM_IDLE) && last) || (go_ok && last);
            reg_we <= (state == CSO_FSM_RUN) && last &&
                      (cur_op == CSO_OP_POP || cur_op == CSO_OP_FL_RD ||
                       cur_op == CSO_OP_FL_RD_INC);
            reg_waddr <= (cur_op == CSO_OP_FL_RD) ? CSO_REG_R0 : cur_reg;
            reg_wdata <= (cur_op == CSO_OP_POP) ? mem_rdata : prog_rdata;
        end
    end

    sequence s_store_end;
        busy ##1 (done && busy) ##1 !busy;
    endsequence
    a_store_two_cycles: assert property (@(posedge clk_sys) disable iff (!rstn)
        go_ok && is_store |=> s_store_end)
        else $error("store did not finish in two cycles");
    a_postinc_value: assert property (@(posedge clk_sys) disable iff (!rstn)
        go_ok && op == CSO_OP_IND_INC |=> ptr_we && ptr_new == $past(ptr) + 16'h0001
        && mem_addr == AW'($past(ptr)))
        else $error("post-increment wrong");
    a_predec_addr: assert property (@(posedge clk_sys) disable iff (!rstn)
        go_ok && op == CSO_OP_IND_DEC |=> mem_we && mem_addr == AW'($past(ptr) - 16'h0001))
        else $error("pre-decrement address wrong");
    a_offset_addr: assert property (@(posedge clk_sys) disable iff (!rstn)
        go_ok && op == CSO_OP_OFFSET |=> !ptr_we &&
        mem_addr == AW'($past(ptr) + {10'h000, $past(disp)}))
        else $error("displacement store wrong");
    sequence s_fl_rd_start;
        go_ok && is_fl_rd;
    endsequence
    a_flash_read_three: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_fl_rd_start |=> prog_re ##1 !done ##1 (done && reg_we))
        else $error("program read not three cycles");
    a_flash_write_word: assert property (@(posedge clk_sys) disable iff (!rstn)
        go_ok && op == CSO_OP_FL_WR |=> prog_we && prog_wdata == $past(r1r0))
        else $error("program write data wrong");
    a_push_sp: assert property (@(posedge clk_sys) disable iff (!rstn)
        go_ok && op == CSO_OP_PUSH |=> mem_addr == AW'($past(sp)) && sp == $past(sp) - 16'h0001
        ##1 done)
        else $error("push stack wrong");
    a_pop_sp: assert property (@(posedge clk_sys) disable iff (!rstn)
        go_ok && op == CSO_OP_POP |=> sp == $past(sp) + 16'h0001 ##1 (done && reg_we))
        else $error("pop stack wrong");
    a_break_idle: assert property (@(posedge clk_sys) disable iff (!rstn)
        debug_break |-> !busy && !mem_we)
        else $error("break started execution");
endmodule
`default_nettype wire

// ### tb/cso_mem_model.sv
/*
 data sram and program flash model for the store unit.
 assumes write strobes last one cycle; data reads answer while
 mem_re stands, flash reads on the next cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module cso_mem_model (
    input  wire logic        clk_sys,
    input  wire logic        mem_we,
    input  wire logic        mem_re,
    input  wire logic [15:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    output logic      [7:0]  mem_rdata,
    input  wire logic        prog_we,
    input  wire logic        prog_re,
    input  wire logic [15:0] prog_addr,
    input  wire logic [15:0] prog_wdata,
    output logic      [7:0]  prog_rdata
);
    logic [7:0] sram  [0:4095];
    logic [7:0] flash [0:255];
    initial begin
        prog_rdata = 8'h00;
    end
    // data read answers while mem_re stands, inverse otherwise
    assign mem_rdata = mem_re ? sram[mem_addr[11:0]] : ~sram[mem_addr[11:0]];
    // flash byte valid one cycle after prog_re, toggles otherwise
    always @(posedge clk_sys) begin
        if (mem_we) sram[mem_addr[11:0]] <= mem_wdata;
        if (prog_we) begin
            flash[{prog_addr[7:1], 1'b0}] <= prog_wdata[7:0];
            flash[{prog_addr[7:1], 1'b1}] <= prog_wdata[15:8];
        end
        prog_rdata <= prog_re ? flash[prog_addr[7:0]] : ~prog_rdata;
    end
endmodule
`default_nettype wire

// ### tb/tb_cpu_store_and_stack_ops.sv
/*
 self-checking bench for the store and stack unit.
 assumes the memory model answers data reads at once, flash reads
 on the next cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_cpu_store_and_stack_ops;
    import cso_pkg::*;
    typedef struct packed {
        cso_op_t     op;
        logic [4:0]  rs;
        logic [15:0] ptr;
        logic [5:0]  disp;
        logic [7:0]  src;
        logic [3:0]  cyc;
        logic [15:0] addr;
        logic [15:0] wd;
        logic [15:0] pn;
        logic [13:0] rwd;
    } cso_row_t;
    logic clk_sys, rstn, start, busy, done, mem_we, mem_re, prog_re, prog_we;
    logic ptr_we, reg_we, debug_break;
    cso_op_t op;
    logic [4:0] reg_sel, reg_waddr;
    logic [5:0] disp;
    logic [7:0] src_data, mem_rdata, prog_rdata, mem_wdata, reg_wdata;
    logic [15:0] ptr, abs_addr, r1r0, mem_addr, prog_addr, prog_wdata, ptr_new, sp;
    logic [15:0] s_addr, s_wd, s_pn;
    logic [13:0] s_rwd;
    int s_cyc, n, error_cnt, check_count, cyc_cnt;
    cso_row_t r;
    cso_row_t rows [12] = '{
        '{CSO_OP_DIRECT, 3, 'h0123, 0, 'h5A, 2, 'h0123, 'h005A, 0, 0},
        '{CSO_OP_IND, 3, 'h0040, 0, 'h11, 2, 'h0040, 'h0011, 0, 0},
        '{CSO_OP_IND_INC, 3, 'h00FF, 0, 'h22, 2, 'h00FF, 'h0022, 'h0100, 0},
        '{CSO_OP_IND_DEC, 3, 'h0100, 0, 'h33, 2, 'h00FF, 'h0033, 'h00FF, 0},
        '{CSO_OP_OFFSET, 3, 'h0200, 'h3F, 'h44, 2, 'h023F, 'h0044, 0, 0},
        '{CSO_OP_PUSH, 3, 0, 0, 'h77, 2, 'h05FF, 'h0077, 0, 0},
        '{CSO_OP_POP, 9, 0, 0, 0, 2, 'h05FF, 0, 0, {1'b1, 8'h77, 5'h09}},
        '{CSO_OP_FL_WR, 3, 'h0010, 0, 0, 2, 'h0010, 'hBEEF, 0, 0},
        '{CSO_OP_FL_RD, 7, 'h0010, 0, 0, 3, 'h0010, 0, 0, {1'b1, 8'hEF, 5'h00}},
        '{CSO_OP_FL_RD_INC, 5, 'h0011, 0, 0, 3, 'h0011, 0, 'h0012, {1'b1, 8'hBE, 5'h05}},
        '{CSO_OP_BREAK, 3, 0, 0, 0, 0, 0, 0, 0, 0},
        '{CSO_OP_NONE, 3, 'h0040, 0, 'h11, 0, 0, 0, 0, 0}};

    cso_exec dut_u (.clk_sys(clk_sys), .rstn(rstn), .start(start), .op(op), .reg_sel(reg_sel),
        .ptr(ptr), .disp(disp), .abs_addr(abs_addr), .src_data(src_data), .r1r0(r1r0),
        .mem_rdata(mem_rdata), .prog_rdata(prog_rdata), .busy(busy), .done(done),
        .mem_we(mem_we), .mem_re(mem_re), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .prog_re(prog_re), .prog_we(prog_we), .prog_addr(prog_addr), .prog_wdata(prog_wdata),
        .ptr_we(ptr_we), .ptr_new(ptr_new), .reg_we(reg_we), .reg_waddr(reg_waddr),
        .reg_wdata(reg_wdata), .debug_break(debug_break), .sp(sp));
    cso_mem_model mem_u (.clk_sys(clk_sys), .mem_we(mem_we), .mem_re(mem_re),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .prog_we(prog_we),
        .prog_re(prog_re), .prog_addr(prog_addr), .prog_wdata(prog_wdata),
        .prog_rdata(prog_rdata));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // issue one op, record strobes until done or six cycles
    task automatic run(input cso_row_t x, input logic hold);
        @(posedge clk_sys);
        op <= x.op;
        reg_sel <= x.rs;
        ptr <= (x.op == CSO_OP_DIRECT) ? 16'h0F0F : x.ptr;
        abs_addr <= x.ptr;
        disp <= x.disp;
        src_data <= x.src;
        start <= 1'b1;
        {s_addr, s_wd, s_pn, s_rwd, s_cyc, n} = '0;
        // n counts cycles from the edge that takes start
        while (n < 6 && s_cyc == 0) begin
            @(posedge clk_sys);
            start <= hold && (n < 2);
            if (hold && n == 0) op <= CSO_OP_IND;
            #1 n++;
            if (mem_we === 1'b1 || mem_re === 1'b1) s_addr = mem_addr;
            if (prog_we === 1'b1 || prog_re === 1'b1) s_addr = prog_addr;
            // a second data write in one op shows as all ones
            if (mem_we === 1'b1) s_wd = (s_wd == 16'h0000) ? {8'h00, mem_wdata} : 16'hFFFF;
            if (prog_we === 1'b1) s_wd = prog_wdata;
            if (ptr_we === 1'b1) s_pn = ptr_new;
            if (reg_we === 1'b1) s_rwd = {1'b1, reg_wdata, reg_waddr};
            if (debug_break === 1'b1) s_rwd = 14'h3FFF;
            if (done === 1'b1) s_cyc = n;
        end
    endtask

    always @(posedge clk_sys) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 3000) begin
            error_cnt++;
            conclude();
        end
    end

    initial begin
        {rstn, start, reg_sel, ptr, disp, abs_addr, src_data} = '0;
        {error_cnt, check_count, cyc_cnt} = '0;
        op = CSO_OP_NONE;
        r1r0 = 16'hBEEF;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        #1 cmp("sp", CSO_SP_RESET, sp);
        cmp("busy", 16'h0, {15'h0, busy});
        cmp("idle strobes", 16'h0, {12'h0, done, mem_we, reg_we, prog_we});
        foreach (rows[i]) begin
            run(rows[i], 1'b0);
            r = rows[i];
            if (r.op == CSO_OP_BREAK) r.rwd = 14'h3FFF;
            if (r.cyc != 4'h0) cmp("cycles", {12'h0, r.cyc}, 16'(s_cyc));
            cmp("addr", r.addr, s_addr);
            cmp("wdata", r.wd, s_wd);
            cmp("ptr_new", r.pn, s_pn);
            cmp("reg write", {2'b00, r.rwd}, {2'b00, s_rwd});
        end
        cmp("sp", CSO_SP_RESET, sp);
        // start held over the busy and done cycles is refused
        run(rows[0], 1'b1);
        cmp("held start", 16'h005A, s_wd);
        @(posedge clk_sys);
        start <= 1'b0;
        repeat (2) begin
            @(posedge clk_sys);
            #1 cmp("held start idle", 16'h0, {14'h0, mem_we, busy});
        end
        run(rows[5], 1'b0);
        run(rows[5], 1'b0);
        cmp("sp", 16'h05FD, sp);
        rstn <= 1'b0;
        @(posedge clk_sys);
        #1 cmp("sp", CSO_SP_RESET, sp);
        cmp("busy", 16'h0, {15'h0, busy});
        @(posedge clk_sys);
        rstn <= 1'b1;
        // first push after a second reset release
        run(rows[5], 1'b0);
        cmp("addr", 16'h05FF, s_addr);
        cmp("wdata", 16'h0077, s_wd);
        cmp("cycles", 16'h0002, 16'(s_cyc));
        cmp("sp", 16'h05FE, sp);
        conclude();
    end
endmodule
`default_nettype wire
